// ===== bench/adc_output_format_overrange_test.sv
// Self-checking bench for the output-code stage
`timescale 1ns/1ns
module adc_output_format_overrange_test;
	logic        I_CLK = 1'b0;
	logic        I_RST_B = 1'b0;
	logic [11:0] raw = 12'h000;
	logic        pos = 1'b0, neg = 1'b0, pc = 1'b0, pin = 1'b0, cfg = 1'b0;
	logic [11:0] o_data, cap_word;
	logic        o_flag, cap_flag;
	int          fails = 0, tests_run = 0;
	adc_output_format_overrange dut (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .i_raw_code(raw),
		.i_over_pos(pos), .i_over_neg(neg), .i_pin_config(pc), .i_format_select_pin(pin),
		.i_cfg_twos_comp(cfg), .o_data(o_data), .o_overrange_flag(o_flag));
	sample_capture rx (.i_clk(I_CLK), .i_word(o_data), .i_flag(o_flag), .o_word(cap_word), .o_flag(cap_flag));
	initial forever #5 I_CLK = ~I_CLK;
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Unused format source gets the opposite choice so a wrong mux shows
	task automatic step(input logic [11:0] r, input logic p, input logic n, input logic m, input logic s);
		@(posedge I_CLK);
		raw <= r;
		pos <= p;
		neg <= n;
		pc  <= m;
		pin <= ~(s ^ m);
		cfg <= s ^ m;
		@(posedge I_CLK);
		#1;
	endtask : step
	task automatic t_format;
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 2; s++) begin
				step(12'h123, 1'b0, 1'b0, m[0], s[0]);
				chk("word", o_data, s ? 12'h923 : 12'h123);
				chk("flag", {11'h000, o_flag}, 12'h000);
			end
		end
	endtask : t_format
	task automatic t_over;
		for (int s = 0; s < 2; s++) begin
			step(12'h456, 1'b1, 1'b0, s[0], s[0]);
			chk("word", o_data, s ? 12'h7ff : 12'hfff);
			chk("flag", {11'h000, o_flag}, 12'h001);
			step(12'h456, 1'b0, 1'b1, 1'b0, s[0]);
			chk("word", o_data, s ? 12'h800 : 12'h000);
			chk("flag", {11'h000, o_flag}, 12'h001);
		end
	endtask : t_over
	task automatic t_persist;
		for (int i = 0; i < 3; i++) begin
			step(12'h000, 1'b0, 1'b1, 1'b1, 1'b0);
			chk("flag", {11'h000, o_flag}, 12'h001);
		end
		step(12'h5a5, 1'b0, 1'b0, 1'b1, 1'b0);
		chk("flag", {11'h000, o_flag}, 12'h000);
		chk("capture", {11'h000, cap_flag}, 12'h001);
	endtask : t_persist
	task automatic end_sim;
		if (fails == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge I_CLK);
		#1;
		chk("reset word", o_data, 12'h000);
		I_RST_B = 1'b1;
		t_format();
		t_over();
		t_persist();
		end_sim();
	end
endmodule : adc_output_format_overrange_test

// ===== bench/sample_capture.sv
// Receiver model that captures each formatted sample word
`timescale 1ns/1ns
module sample_capture (
	input  wire logic        i_clk,
	input  wire logic [11:0] i_word,
	input  wire logic        i_flag,
	output logic      [11:0] o_word,
	output logic             o_flag
);
	// One word per rising edge, no backpressure
	always_ff @(posedge i_clk) begin
		o_word <= i_word;
		o_flag <= i_flag;
	end
endmodule : sample_capture

// ===== design/adc_output_format_overrange.sv
// Output-code stage: format selection, overload clamping and over-range flag
`timescale 1ns/1ns
module adc_output_format_overrange #(
	parameter int DATA_WIDTH = 12
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	input  wire logic [11:0] i_raw_code,
	input  wire logic        i_over_pos,
	input  wire logic        i_over_neg,
	input  wire logic        i_pin_config,
	input  wire logic        i_format_select_pin,
	input  wire logic        i_cfg_twos_comp,
	output logic      [11:0] o_data,
	output logic             o_overrange_flag
);
	// ******************************
	// Checks
	// ******************************
	initial begin
		if (DATA_WIDTH != fmt_pkg::DATA_W)
			$error("Only a 12-bit word is supported");
	end

	code_if cif ();

	range_class u_class (
		.i_raw      (i_raw_code),
		.i_over_pos (i_over_pos),
		.i_over_neg (i_over_neg),
		.cif        (cif)
	);

	// ******************************
	// Format and clamp
	// ******************************
	logic        twos_sel;
	logic [11:0] ob_word;
	logic [11:0] nxt_data;
	logic        nxt_flag;
	logic [11:0] data_ff;
	logic        flag_ff;

	always_comb begin
		twos_sel = i_pin_config ? i_format_select_pin : i_cfg_twos_comp; // RQ6
		case (cif.range)
			fmt_pkg::RANGE_POS: ob_word = fmt_pkg::POS_FULL_OB; // RQ4
			fmt_pkg::RANGE_NEG: ob_word = fmt_pkg::NEG_FULL_OB; // RQ5
			fmt_pkg::RANGE_OK:  ob_word = cif.raw;
			default:            ob_word = cif.raw;
		endcase
		// Same path for both formats, so no extra latency either way
		nxt_data = twos_sel ? (ob_word ^ fmt_pkg::MSB_FLIP) : ob_word; // RQ7
		// No dependence on the sample interface type at all
		nxt_flag = (cif.range != fmt_pkg::RANGE_OK); // RQ1 RQ2 RQ3
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			data_ff <= fmt_pkg::WORD_RST;
			flag_ff <= fmt_pkg::FLAG_RST;
		end else begin
			data_ff <= nxt_data;
			flag_ff <= nxt_flag;
		end
	end

	assign o_data           = data_ff;
	assign o_overrange_flag = flag_ff;

	// ******************************
	// Assertions
	// ******************************
	logic fmt_twos;
	assign fmt_twos = i_pin_config ? i_format_select_pin : i_cfg_twos_comp;

	flag_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ1
		(i_over_pos || i_over_neg) |=> o_overrange_flag)
		else $error("Over-range flag not raised");
	flag_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ2
		!(i_over_pos || i_over_neg) |=> !o_overrange_flag)
		else $error("Over-range flag not released");
	flag_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ2
		(i_over_pos || i_over_neg) [*3] |=> o_overrange_flag && $past(o_overrange_flag))
		else $error("Over-range flag dropped during overload");
	flag_fmt_free_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ3
		$changed(fmt_twos) && $stable(i_over_pos) && $stable(i_over_neg) && $past(I_RST_B)
		|=> $stable(o_overrange_flag))
		else $error("Flag depends on format");
	pos_clamp_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ4
		i_over_pos |=> o_data == ($past(fmt_twos) ? 12'h7ff : 12'hfff))
		else $error("Positive clamp code wrong");
	neg_clamp_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ5
		(i_over_neg && !i_over_pos) |=> o_data == ($past(fmt_twos) ? 12'h800 : 12'h000))
		else $error("Negative clamp code wrong");
	pin_select_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ6
		(i_pin_config && !i_over_pos && !i_over_neg)
		|=> o_data[11] == ($past(i_raw_code[11]) ^ $past(i_format_select_pin)))
		else $error("Format pin not honoured");
	twos_map_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ7
		(!i_over_pos && !i_over_neg)
		|=> o_data == {$past(i_raw_code[11]) ^ $past(fmt_twos), $past(i_raw_code[10:0])})
		else $error("Format mapping or latency wrong");

	pos_cov_c:  cover property (@(posedge I_CLK) disable iff (!I_RST_B) i_over_pos ##1 o_overrange_flag);
	neg_cov_c:  cover property (@(posedge I_CLK) disable iff (!I_RST_B) i_over_neg && fmt_twos);
	back_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RST_B)
		o_overrange_flag ##1 !o_overrange_flag);
	pin_cov_c:  cover property (@(posedge I_CLK) disable iff (!I_RST_B) i_pin_config && i_format_select_pin);
endmodule : adc_output_format_overrange

// ===== design/range_class.sv
// Classifies each raw sample from the positive and negative overload inputs, not from its code
`timescale 1ns/1ns
module range_class (
	input  wire logic [11:0] i_raw,
	input  wire logic        i_over_pos,
	input  wire logic        i_over_neg,
	code_if.src              cif
);
	// Positive wins if both are reported; a bad converter state must still clamp
	always_comb begin
		cif.raw = i_raw;
		if (i_over_pos)
			cif.range = fmt_pkg::RANGE_POS;
		else if (i_over_neg)
			cif.range = fmt_pkg::RANGE_NEG;
		else
			cif.range = fmt_pkg::RANGE_OK;
	end
endmodule : range_class

// ===== inc/code_if.sv
// Interface joining the range classifier to the output stage
`timescale 1ns/1ns
interface code_if;
	logic [11:0]         raw;
	fmt_pkg::range_type  range;
	modport src (output raw, output range);
	modport dst (input raw, input range);
endinterface : code_if

// ===== inc/fmt_pkg.sv
// Constants for the output-code formatting stage
//
// Functional notes
// RQ1: Over-range flag goes high on any cycle the sample exceeds either full-scale limit.
// RQ2: Flag stays high while overload persists, drops once samples return in range.
// RQ3: Flag is single-ended and independent of the selected sample interface type.
// RQ4: Positive overload gives all ones offset binary, largest positive two's complement.
// RQ5: Negative overload gives all zeros offset binary, most negative two's complement.
// RQ6: Format selectable by configuration bit, or format-select pin in pin mode.
// RQ7: Two's complement equals offset binary with MSB inverted, no extra latency.
package fmt_pkg;
	localparam int          DATA_W        = 12;
	localparam logic [11:0] POS_FULL_OB   = 12'hfff;
	localparam logic [11:0] NEG_FULL_OB   = 12'h000;
	localparam logic [11:0] MSB_FLIP      = 12'h800;
	localparam logic [11:0] WORD_RST      = 12'h000;
	localparam logic        FLAG_RST      = 1'b0;
	typedef enum logic [1:0] {
		RANGE_OK  = 2'b00,
		RANGE_POS = 2'b01,
		RANGE_NEG = 2'b10
	} range_type;
endpackage : fmt_pkg
